// File: sim/bmr_bus_model.sv
// bus engine standing for host and charger, taking broadcast words
// assumes the sequencer holds each offered word until bc_ready
`timescale 1ns/10ps
module bmr_bus_model (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        slow,
    input wire logic        bc_valid,
    input wire logic [6:0]  bc_addr,
    input wire logic [7:0]  bc_cmd,
    input wire logic [15:0] bc_data,
    output logic            bc_ready
);
    logic [1:0]  wait_q = 2'h0;
    logic [30:0] log_q[$];
    wire         take = bc_valid && !bc_ready && !sys_rst;
    wire         acc  = take && (!slow || wait_q == 2'h3);
    // a slow engine stalls each word three cycles, as a busy bus would
    always @(posedge clk) begin
        bc_ready <= acc;
        wait_q   <= take ? wait_q + 2'h1 : 2'h0;
        if (acc) log_q.push_back({bc_addr, bc_cmd, bc_data});
    end
endmodule

// File: sim/bmr_regs_monitor.sv
// checker for read words and broadcast word order of bmr_regs
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module bmr_regs_monitor
    import bmr_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    input wire logic        cmd_valid,
    input wire logic        cmd_write,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_rdata,
    input wire logic [15:0] temp_dk,
    input wire logic [15:0] volt_mv,
    input wire logic        bc_valid,
    input wire logic [6:0]  bc_addr,
    input wire logic [7:0]  bc_cmd,
    input wire logic        bc_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // a read is only taken with ce high, so ce gates every read property
    wire rd_c = cmd_valid && ce && !cmd_write;
    wire hs   = bc_valid && bc_ready;

    a_mode_reserved: assert property (rd_c && cmd_code == CMD_MODE_WORD |=>
        {cmd_rdata[12:10], cmd_rdata[6:2]} == 8'h00) else $error("reserved bits set");
    a_temp_word: assert property (rd_c && cmd_code == CMD_TEMPERATURE |=>
        cmd_rdata == $past(temp_dk)) else $error("temperature word wrong");
    a_volt_clamp: assert property (rd_c && cmd_code == CMD_VOLTAGE |=>
        cmd_rdata == ($past(volt_mv) > VOLT_MAX_MV ? VOLT_MAX_MV : $past(volt_mv)))
        else $error("voltage word wrong");
    a_ok_boolean: assert property (rd_c && cmd_code == CMD_RATE_OK |=>
        cmd_rdata[15:1] == 15'h0) else $error("can-deliver not boolean");
    a_word_held: assert property (bc_valid && !bc_ready |=>
        bc_valid && $stable(bc_addr) && $stable(bc_cmd)) else $error("word dropped");
    a_alarm_pair: assert property (hs && bc_addr == ADDR_HOST && bc_cmd == CMD_ALARM_MSG |=>
        bc_valid && bc_addr == ADDR_CHARGER && bc_cmd == CMD_ALARM_MSG) else $error("alarm pair");
    a_charge_pair: assert property (hs && bc_cmd == CMD_CHG_CURRENT |=>
        bc_valid && bc_addr == ADDR_CHARGER && bc_cmd == CMD_CHG_VOLTAGE)
        else $error("charge pair");
    a_host_first: assert property ($rose(bc_valid) && bc_cmd == CMD_ALARM_MSG |->
        bc_addr == ADDR_HOST) else $error("alarm not to host first");
    c_alarm: cover property (hs && bc_cmd == CMD_ALARM_MSG);
    c_charge: cover property (hs && bc_cmd == CMD_CHG_VOLTAGE);
    c_mode_read: cover property (rd_c && cmd_code == CMD_MODE_WORD);
endmodule

bind bmr_regs bmr_regs_monitor i_bmr_regs_monitor (.*);

// File: sim/tb_top.sv
// bench for mode word, broadcasts, rate queries and read words
// assumes a 20-cycle tick, so the inhibit spans about 1200 cycles
`timescale 1ns/10ps
module tb_top
    import bmr_pkg::*;
#(parameter int TC = 20);
    logic        clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, slow = 1'b0, cmd_valid = 1'b0;
    logic        cmd_write = 1'b0, sleep_enter = 1'b0, alarm_cond = 1'b0, charge_req = 1'b0;
    logic        relearn_request = 1'b1, main_pack_role_capable = 1'b0;
    logic        onboard_charge_ctrl_capable = 1'b1;
    logic [7:0]  cmd_code = 8'h00, bc_cmd;
    logic [15:0] cmd_wdata = 16'h0000, alarm_status = 16'h0A5A, temp_dk = 16'h0BA4;
    logic [15:0] desired_charge_current = 16'h0BB8, desired_charge_voltage = 16'h3070;
    logic [15:0] remain_cap = 16'h0064, to_full_cap = 16'h0064, volt_mv = 16'h7530;
    logic [15:0] cmd_rdata, bc_data;
    logic [6:0]  bc_addr;
    logic        cmd_ack, cmd_refused, capacity_unit_10mw, onboard_charge_ctrl_on;
    logic        main_pack_role, bc_valid, bc_ready;
    int          n_errors = 0, checks = 0;

    always #4 clk = ~clk;
    bmr_regs #(.TICK_CYCLES(TC)) i_bmr_regs (.*);
    bmr_bus_model i_bmr_bus_model (.*);

    task automatic chk(input logic [30:0] got, input logic [30:0] exp);
        checks++;
        if (got !== exp) n_errors++;
        if (got !== exp) $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one command held for one edge; the answer is looked at just after the ack edge
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        {cmd_valid, cmd_write, cmd_code, cmd_wdata} <= {1'b1, w, c, d};
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1 chk(31'(cmd_ack), 31'h1);
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        cmd(1'b0, c, 16'h0000);
        chk(31'(cmd_rdata), 31'(e));
    endtask
    // rate write, then a wait well inside the refresh bound
    task automatic rate(input logic [15:0] cap, input logic [15:0] d);
        @(posedge clk);
        remain_cap <= cap;
        cmd(1'b1, CMD_RATE_VALUE, d);
        repeat (80) @(posedge clk);
    endtask
    task automatic strobe(input logic s, input logic c);
        @(posedge clk);
        {sleep_enter, charge_req} <= {s, c};
        @(posedge clk);
        {sleep_enter, charge_req} <= 2'b00;
    endtask
    task automatic wait_words(input int n, input int bound);
        for (int i = 0; i < bound && i_bmr_bus_model.log_q.size() < n; i++) @(posedge clk);
        if (i_bmr_bus_model.log_q.size() < n) n_errors++;
        if (i_bmr_bus_model.log_q.size() < n) tally_and_finish();
    endtask

    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd(CMD_MODE_WORD, 16'h0081);
        rd(CMD_RATE_TTE, MIN_INVALID);
        rd(CMD_RATE_OK, 16'h0001);
        cmd(1'b1, CMD_MODE_WORD, 16'hFFFF);
        rd(CMD_MODE_WORD, 16'hE381);
        chk(31'(capacity_unit_10mw), 31'h1);
        chk(31'({onboard_charge_ctrl_on, main_pack_role}), 31'h3);
        @(posedge clk);
        {relearn_request, main_pack_role_capable, slow} <= 3'b011;
        strobe(1'b1, 1'b0);
        rd(CMD_MODE_WORD, 16'h0303);
        strobe(1'b0, 1'b1);
        wait_words(2, 40);
        chk(i_bmr_bus_model.log_q[0], {ADDR_CHARGER, CMD_CHG_CURRENT, 16'h0BB8});
        chk(i_bmr_bus_model.log_q[1], {ADDR_CHARGER, CMD_CHG_VOLTAGE, 16'h3070});
        cmd(1'b1, CMD_MODE_WORD, 16'h4000);
        strobe(1'b0, 1'b1);
        repeat (40) @(posedge clk);
        chk(31'(i_bmr_bus_model.log_q.size()), 31'h2);
        cmd(1'b1, CMD_MODE_WORD, 16'h6000);
        @(posedge clk);
        {alarm_cond, slow} <= 2'b10;
        repeat (58 * TC) @(posedge clk);
        chk(31'(i_bmr_bus_model.log_q.size()), 31'h2);
        wait_words(4, 3 * TC);
        chk(i_bmr_bus_model.log_q[2], {ADDR_HOST, CMD_ALARM_MSG, alarm_status});
        chk(i_bmr_bus_model.log_q[3], {ADDR_CHARGER, CMD_ALARM_MSG, alarm_status});
        rd(CMD_MODE_WORD, 16'h4003);
        repeat (9 * TC) @(posedge clk);
        chk(31'(i_bmr_bus_model.log_q.size()), 31'h4);
        wait_words(6, 3 * TC);
        rate(16'h0064, 16'hFF9C);
        rd(CMD_RATE_TTE, 16'h003C);
        rd(CMD_RATE_OK, 16'h0001);
        rd(CMD_RATE_TTF, MIN_INVALID);
        rate(16'h0032, 16'h8AD0);
        rd(CMD_RATE_TTE, 16'h0000);
        rd(CMD_RATE_OK, 16'h0000);
        rate(16'h0032, 16'h00C8);
        rd(CMD_RATE_VALUE, 16'h00C8);
        rd(CMD_RATE_TTF, 16'h001E);
        rd(CMD_RATE_TTE, MIN_INVALID);
        rd(CMD_RATE_OK, 16'h0001);
        rd(CMD_VOLTAGE, VOLT_MAX_MV);
        @(posedge clk);
        {volt_mv, temp_dk} <= {16'h2EE0, 16'h0C1C};
        rd(CMD_VOLTAGE, 16'h2EE0);
        rd(CMD_TEMPERATURE, 16'h0C1C);
        cmd(1'b1, CMD_VOLTAGE, 16'h0001);
        chk(31'(cmd_refused), 31'h1);
        rd(8'h30, 16'h0000);
        chk(31'(cmd_refused), 31'h1);
        tally_and_finish();
    end
endmodule

// File: src/bmr_div.sv
// serial restoring divider, one quotient bit per enabled cycle
// assumes divisor is non-zero when start is raised
`timescale 1ns/10ps
module bmr_div #(
    parameter int NW = 32,
    parameter int DW = 16
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          ce,
    input  wire logic          start,
    input  wire logic [NW-1:0] dividend,
    input  wire logic [DW-1:0] divisor,
    output logic               busy,
    output logic               done,
    output logic [NW-1:0]      quotient
);
    localparam int KW = $clog2(NW + 1);

    logic [DW:0]   rem_q, rem_d;
    logic [NW-1:0] quo_q, quo_d;
    logic [DW-1:0] dsr_q, dsr_d;
    logic [KW-1:0] cnt_q, cnt_d;
    logic          done_q, done_d;
    logic [DW:0]   trial;

    // ------------------------------------------------------------------
    // shift-subtract step
    // ------------------------------------------------------------------
    // NW cycles; slow but tiny, far inside the refresh deadline
    always_comb begin
        rem_d  = rem_q;
        quo_d  = quo_q;
        dsr_d  = dsr_q;
        cnt_d  = cnt_q;
        done_d = 1'b0;
        trial  = {rem_q[DW-1:0], quo_q[NW-1]};
        if (start && cnt_q == '0) begin
            rem_d = '0;
            quo_d = dividend;
            dsr_d = divisor;
            cnt_d = KW'(NW);
        end else if (cnt_q != '0) begin
            quo_d = {quo_q[NW-2:0], 1'b0};
            rem_d = trial;
            if (trial >= {1'b0, dsr_q}) begin
                rem_d    = trial - {1'b0, dsr_q};
                quo_d[0] = 1'b1;
            end
            cnt_d  = cnt_q - 1'b1;
            done_d = (cnt_q == KW'(1));
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rem_q  <= '0;
            quo_q  <= '0;
            dsr_q  <= '0;
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else if (ce) begin
            rem_q  <= rem_d;
            quo_q  <= quo_d;
            dsr_q  <= dsr_d;
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy     = (cnt_q != '0);
    assign done     = done_q & ce;
    assign quotient = quo_q;

endmodule

// File: src/bmr_pkg.sv
// constants for the pack mode word, rate queries and alarm/charge broadcasts
// assumes a 125 MHz system clock and a 1 s tick built from it
package bmr_pkg;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_MODE_WORD   = 8'h03;
    localparam logic [7:0]  CMD_RATE_VALUE  = 8'h04;
    localparam logic [7:0]  CMD_RATE_TTF    = 8'h05;
    localparam logic [7:0]  CMD_RATE_TTE    = 8'h06;
    localparam logic [7:0]  CMD_RATE_OK     = 8'h07;
    localparam logic [7:0]  CMD_TEMPERATURE = 8'h08;
    localparam logic [7:0]  CMD_VOLTAGE     = 8'h09;
    localparam logic [7:0]  CMD_ALARM_MSG   = 8'h16;
    localparam logic [7:0]  CMD_CHG_CURRENT = 8'h14;
    localparam logic [7:0]  CMD_CHG_VOLTAGE = 8'h15;

    // ------------------------------------------------------------------
    // broadcast target addresses (7-bit)
    // ------------------------------------------------------------------
    localparam logic [6:0]  ADDR_CHARGER    = 7'h12;
    localparam logic [6:0]  ADDR_HOST       = 7'h10;

    // ------------------------------------------------------------------
    // mode word layout and reset values
    // ------------------------------------------------------------------
    localparam int          MODE_INT_CHG    = 0;
    localparam int          MODE_MAIN_CAP   = 1;
    localparam int          MODE_RELEARN    = 7;
    localparam int          MODE_CHG_ON     = 8;
    localparam int          MODE_MAIN_ROLE  = 9;
    localparam int          MODE_ALARM_INH  = 13;
    localparam int          MODE_CHG_INH    = 14;
    localparam int          MODE_CAP_UNIT   = 15;
    localparam logic [15:0] MODE_WR_MASK    = 16'hE300;
    localparam logic [15:0] MODE_SLEEP_CLR  = 16'hE000;
    localparam logic [15:0] MODE_RESET      = 16'h0000;
    localparam logic [15:0] RATE_RESET      = 16'h0000;

    // ------------------------------------------------------------------
    // result encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] MIN_INVALID     = 16'hFFFF;
    localparam logic [15:0] MIN_MAX         = 16'hFFFE;
    localparam logic [15:0] VOLT_MAX_MV     = 16'h4E20;
    localparam logic [31:0] MIN_PER_HOUR    = 32'h0000003C;
    localparam logic [31:0] SEC_PER_HOUR    = 32'h00000E10;

    // ------------------------------------------------------------------
    // times and derived cycle counts
    // ------------------------------------------------------------------
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          TICK_S          = 1;
    localparam int          SECOND_CYCLES   = CLK_HZ * TICK_S;
    localparam int          INHIBIT_S       = 60;
    localparam int          ALARM_GAP_S     = 10;
    localparam int          DELIVER_S       = 10;
    // free-running tick: n ticks span n-1..n seconds
    localparam logic [5:0]  INHIBIT_TICKS   = 6'(INHIBIT_S / TICK_S);
    localparam logic [3:0]  ALARM_GAP_TICKS = 4'(ALARM_GAP_S / TICK_S + 1);
    localparam logic [31:0] DELIVER_FACTOR  = 32'(3600 / DELIVER_S);

endpackage

// File: src/bmr_regs.sv
// pack mode word, rate-query results, read words and broadcast sequencer
// assumes an external bus engine frames commands and carries broadcasts
//
// Operation
// - mode bit 7 is read-only recalibration request; bits 2-6, 10-12 reserved.
// - bit 13 read/write alarm broadcast inhibit, default 0; bits 14, 15 read/write.
// - while inhibit set, no bus mastering nor alarm messages, 59 to 60 s.
// - inhibit clear: alarm message to host and charger on alarm condition.
// - successive alarm broadcasts spaced at least 10 s apart.
// - each mode command restarts 60 s timer; expiry clears alarm inhibit.
// - sleep clears alarm inhibit, charge inhibit and unit select.
// - alarm inhibit never affects the charge-request inhibit bit.
// - charge inhibit set stops desired current and voltage messages.
// - unit select: 1 reports 10 mW units, 0 reports mA units.
// - unit change refreshes values within 1 s; rate results on write or tick.
// - command 0x04 holds rate value feeding rate results; written before reading.
// - rate time-to-full in minutes, 65535 when rate zero or negative.
// - rate time-to-empty at 0x06, 0 to 65534, 65535 when rate not negative.
// - time-to-empty recomputed within 5 ms of rate write and every 1 s.
// - can-deliver at 0x07 says rate sustainable 10 s; 1 when rate not negative.
// - can-deliver recomputed within 5 ms of rate write and every 1 s.
// - temperature word at 0x08 in units of 0.1 kelvin.
// - voltage word at 0x09 in millivolts, 0 to 20000.
// - broadcasts are write words to charger 0x12 and host 0x10.
`timescale 1ns/10ps
module bmr_regs
    import bmr_pkg::*;
#(
    parameter int TICK_CYCLES = SECOND_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic [15:0]      cmd_rdata,
    output logic             cmd_ack,
    output logic             cmd_refused,
    input  wire logic        onboard_charge_ctrl_capable,
    input  wire logic        main_pack_role_capable,
    input  wire logic        relearn_request,
    input  wire logic        sleep_enter,
    input  wire logic        alarm_cond,
    input  wire logic [15:0] alarm_status,
    input  wire logic        charge_req,
    input  wire logic [15:0] desired_charge_current,
    input  wire logic [15:0] desired_charge_voltage,
    input  wire logic [15:0] remain_cap,
    input  wire logic [15:0] to_full_cap,
    input  wire logic [15:0] temp_dk,
    input  wire logic [15:0] volt_mv,
    output logic             capacity_unit_10mw,
    output logic             onboard_charge_ctrl_on,
    output logic             main_pack_role,
    output logic             bc_valid,
    output logic [6:0]       bc_addr,
    output logic [7:0]       bc_cmd,
    output logic [15:0]      bc_data,
    input  wire logic        bc_ready
);

    typedef enum {BC_IDLE, BC_ALM_HOST, BC_ALM_CHG, BC_CUR, BC_VOLT} bmr_bc_type;

    logic        tick;
    logic        div_start;
    logic        div_busy;
    logic        div_done;
    logic [31:0] div_quot;
    logic        mode_cmd;
    logic        rate_wr;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    bmr_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .tick    (tick)
    );

    // ------------------------------------------------------------------
    // mode word and alarm inhibit timer
    // ------------------------------------------------------------------
    logic [15:0] mode_q, mode_d;
    logic [5:0]  inh_cnt_q, inh_cnt_d;
    logic [15:0] mode_rd;

    assign mode_cmd = cmd_valid && cmd_code == CMD_MODE_WORD;
    assign rate_wr  = cmd_valid && cmd_write && cmd_code == CMD_RATE_VALUE;

    // read-only flags come straight from their sources; reserved read 0
    always_comb begin
        mode_rd                = mode_q & MODE_WR_MASK;
        mode_rd[MODE_INT_CHG]  = onboard_charge_ctrl_capable;
        mode_rd[MODE_MAIN_CAP] = main_pack_role_capable;
        mode_rd[MODE_RELEARN]  = relearn_request;
    end

    always_comb begin
        mode_d    = mode_q;
        inh_cnt_d = inh_cnt_q;
        if (tick && inh_cnt_q != '0) begin
            inh_cnt_d = inh_cnt_q - 1'b1;
            if (inh_cnt_q == 6'h01) begin
                mode_d[MODE_ALARM_INH] = 1'b0;
            end
        end
        if (mode_cmd) begin
            inh_cnt_d = INHIBIT_TICKS;
        end
        if (mode_cmd && cmd_write) begin
            // each bit written on its own
            mode_d = (mode_q & ~MODE_WR_MASK) | (cmd_wdata & MODE_WR_MASK);
        end
        if (sleep_enter) begin
            mode_d    = mode_d & ~MODE_SLEEP_CLR;
            inh_cnt_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q    <= MODE_RESET;
            inh_cnt_q <= '0;
        end else if (ce) begin
            mode_q    <= mode_d;
            inh_cnt_q <= inh_cnt_d;
        end
    end

    // unit select drives the gauge core
    assign capacity_unit_10mw     = mode_q[MODE_CAP_UNIT];
    assign onboard_charge_ctrl_on = mode_q[MODE_CHG_ON];
    assign main_pack_role         = mode_q[MODE_MAIN_ROLE];

    // ------------------------------------------------------------------
    // rate value and rate-query results
    // ------------------------------------------------------------------
    logic [15:0] rate_q, rate_d;
    logic        pend_q, pend_d;
    logic        neg_q, neg_d;
    logic [15:0] tte_q, tte_d;
    logic [15:0] ttf_q, ttf_d;
    logic        ok_q, ok_d;
    logic [15:0] rate_mag;
    logic [31:0] div_num;
    logic [15:0] quot_sat;

    // magnitude of the signed rate; 0x8000 maps to 32768, still fits
    assign rate_mag = rate_q[15] ? 16'(-rate_q) : rate_q;
    assign div_num  = (rate_q[15] ? {16'h0000, remain_cap} : {16'h0000, to_full_cap})
                      * MIN_PER_HOUR;
    assign quot_sat = (div_quot > {16'h0000, MIN_MAX}) ? MIN_MAX : div_quot[15:0];
    assign div_start = pend_q && !div_busy && rate_q != '0;

    // a tick or a write landing mid-division is kept pending, not lost
    always_comb begin
        rate_d = rate_q;
        pend_d = pend_q;
        neg_d  = neg_q;
        tte_d  = tte_q;
        ttf_d  = ttf_q;
        ok_d   = ok_q;
        if (rate_wr) begin
            rate_d = cmd_wdata;
        end
        if (div_done) begin
            // negative rate gives minutes to empty
            tte_d = neg_q ? quot_sat : MIN_INVALID;
            // positive rate gives minutes to full
            ttf_d = neg_q ? MIN_INVALID : quot_sat;
        end
        if (pend_q && !div_busy) begin
            pend_d = 1'b0;
            neg_d  = rate_q[15];
            ok_d   = !rate_q[15] ||
                     ({16'h0000, remain_cap} * DELIVER_FACTOR >= {16'h0000, rate_mag});
            if (rate_q == '0) begin
                tte_d = MIN_INVALID;
                ttf_d = MIN_INVALID;
            end
        end
        // recompute on write or 1 s tick
        // unit change picked up on next refresh
        if (rate_wr || tick) begin
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rate_q <= RATE_RESET;
            pend_q <= 1'b1;
            neg_q  <= 1'b0;
            tte_q  <= MIN_INVALID;
            ttf_q  <= MIN_INVALID;
            ok_q   <= 1'b1;
        end else if (ce) begin
            rate_q <= rate_d;
            pend_q <= pend_d;
            neg_q  <= neg_d;
            tte_q  <= tte_d;
            ttf_q  <= ttf_d;
            ok_q   <= ok_d;
        end
    end

    bmr_div #(.NW(32), .DW(16)) u_div (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .start    (div_start),
        .dividend (div_num),
        .divisor  (rate_mag),
        .busy     (div_busy),
        .done     (div_done),
        .quotient (div_quot)
    );

    // ------------------------------------------------------------------
    // command read port
    // ------------------------------------------------------------------
    logic [15:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic        ref_q, ref_d;

    // writes to read-only or unknown codes are answered but flagged
    always_comb begin
        rdata_d = '0;
        ack_d   = cmd_valid;
        ref_d   = 1'b0;
        case (cmd_code)
            CMD_MODE_WORD:   rdata_d = mode_rd;
            CMD_RATE_VALUE:  rdata_d = rate_q;
            CMD_RATE_TTF:    rdata_d = ttf_q;
            CMD_RATE_TTE:    rdata_d = tte_q;
            CMD_RATE_OK:     rdata_d = {15'h0000, ok_q};
            CMD_TEMPERATURE: rdata_d = temp_dk;
            CMD_VOLTAGE:     rdata_d = (volt_mv > VOLT_MAX_MV) ? VOLT_MAX_MV : volt_mv;
            default:         ref_d = cmd_valid;
        endcase
        if (cmd_valid && cmd_write && cmd_code != CMD_MODE_WORD
            && cmd_code != CMD_RATE_VALUE) begin
            ref_d = 1'b1;
        end
        if (!cmd_valid) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
            ack_q   <= 1'b0;
            ref_q   <= 1'b0;
        end else if (ce) begin
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            ref_q   <= ref_d;
        end
    end

    assign cmd_rdata   = rdata_q;
    assign cmd_ack     = ack_q;
    assign cmd_refused = ref_q;

    // ------------------------------------------------------------------
    // broadcast sequencer
    // ------------------------------------------------------------------
    bmr_bc_type  st_q, st_d;
    logic [3:0]  gap_q, gap_d;
    logic        chg_pend_q, chg_pend_d;
    logic [6:0]  addr_q, addr_d;
    logic [7:0]  bcmd_q, bcmd_d;
    logic [15:0] bdata_q, bdata_d;
    logic        inhibit;

    assign inhibit = mode_q[MODE_ALARM_INH];

    // a message already offered is finished even if inhibit rises meanwhile
    always_comb begin
        st_d       = st_q;
        gap_d      = gap_q;
        chg_pend_d = chg_pend_q;
        addr_d     = addr_q;
        bcmd_d     = bcmd_q;
        bdata_d    = bdata_q;
        // spacing counts down from the last alarm
        if (tick && gap_q != '0) begin
            gap_d = gap_q - 1'b1;
        end
        case (st_q)
            BC_IDLE: begin
                if (!inhibit && alarm_cond && gap_q == '0) begin
                    st_d    = BC_ALM_HOST;
                    addr_d  = ADDR_HOST;
                    bcmd_d  = CMD_ALARM_MSG;
                    bdata_d = alarm_status;
                end else if (!inhibit && chg_pend_q && !mode_q[MODE_CHG_INH]) begin
                    st_d       = BC_CUR;
                    chg_pend_d = 1'b0;
                    addr_d     = ADDR_CHARGER;
                    bcmd_d     = CMD_CHG_CURRENT;
                    bdata_d    = desired_charge_current;
                end
            end
            BC_ALM_HOST: if (bc_ready) begin
                st_d   = BC_ALM_CHG;
                addr_d = ADDR_CHARGER;
            end
            BC_ALM_CHG: if (bc_ready) begin
                st_d  = BC_IDLE;
                gap_d = ALARM_GAP_TICKS;
            end
            BC_CUR: if (bc_ready) begin
                st_d    = BC_VOLT;
                bcmd_d  = CMD_CHG_VOLTAGE;
                bdata_d = desired_charge_voltage;
            end
            BC_VOLT: if (bc_ready) begin
                st_d = BC_IDLE;
            end
            default: st_d = BC_IDLE;
        endcase
        if (mode_q[MODE_CHG_INH]) begin
            chg_pend_d = 1'b0;
        end else if (charge_req) begin
            chg_pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q       <= BC_IDLE;
            gap_q      <= '0;
            chg_pend_q <= 1'b0;
            addr_q     <= '0;
            bcmd_q     <= '0;
            bdata_q    <= '0;
        end else if (ce) begin
            st_q       <= st_d;
            gap_q      <= gap_d;
            chg_pend_q <= chg_pend_d;
            addr_q     <= addr_d;
            bcmd_q     <= bcmd_d;
            bdata_q    <= bdata_d;
        end
    end

    assign bc_valid = (st_q != BC_IDLE);
    assign bc_addr  = addr_q;
    assign bc_cmd   = bcmd_q;
    assign bc_data  = bdata_q;

endmodule

// File: src/bmr_tick_gen.sv
// free-running one-second tick for the mode word timers and rate refresh
// assumes a single clock; ce low freezes the prescaler
`timescale 1ns/10ps
module bmr_tick_gen
    import bmr_pkg::*;
#(
    parameter int TICK_CYCLES = SECOND_CYCLES
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    output logic      tick
);
    localparam int CW = $clog2(TICK_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          tick_q;
    logic          tick_d;

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    // tick is registered so consumers see a clean one-cycle pulse
    always_comb begin
        cnt_d  = cnt_q + 1'b1;
        tick_d = 1'b0;
        if (cnt_q == LAST) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q & ce;

endmodule
